// ==== pkg/pbpm_pkg.sv ====
// Purpose: constants for the port B/C/D pin mux and port C registers
// Assumes: APB word registers, byte address is four times the index
// Notes:   port C holds pins 0 to 8 and 12 only
package pbpm_pkg;
  // port C geometry
  localparam int          PC_W        = 16;
  localparam logic [15:0] PC_PIN_MASK = 16'h11ff;
  ////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [3:0] IDX_PULLUP   = 4'h0;
  localparam logic [3:0] IDX_DATA     = 4'h1;
  localparam logic [3:0] IDX_DIR      = 4'h2;
  localparam logic [3:0] IDX_PERSEL   = 4'h3;
  localparam logic [3:0] IDX_IRQ_ASRT = 4'h4;
  localparam logic [3:0] IDX_IRQ_EN   = 4'h5;
  localparam logic [3:0] IDX_IRQ_POL  = 4'h6;
  localparam logic [3:0] IDX_IRQ_PEND = 4'h7;
  localparam logic [3:0] IDX_EDGE     = 4'h8;
  localparam logic [3:0] IDX_PUSHPULL = 4'h9;
  localparam logic [3:0] IDX_RAW      = 4'ha;
  localparam logic [3:0] IDX_DRIVE    = 4'hb;
  localparam logic [3:0] IDX_PIN_FUNC = 4'hc;
  localparam logic [3:0] IDX_CD_FUNC  = 4'hd;
  ////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] RST_PULLUP   = 16'hffff;
  localparam logic [15:0] RST_PUSHPULL = 16'hffff;
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  ////////////////////////////////////////////////////////////////////
  // select field positions
  localparam int F_B3 = 0;
  localparam int F_B5 = 2;
  localparam int F_B6 = 4;
  localparam int F_B7 = 6;
  localparam int F_B8 = 8;
  localparam int F_B9 = 10;
  localparam int F_C0 = 12;
  localparam int F_C2 = 13;
  localparam int F_C3 = 14;
  localparam int F_C4 = 15;
  localparam int F_D5 = 0;
  // select codes
  localparam logic [1:0] SEL_GPIO = 2'h0;
  localparam logic [1:0] SEL_FN1  = 2'h1;
  localparam logic [1:0] SEL_FN2  = 2'h2;
  localparam logic [1:0] SEL_FN3  = 2'h3;
  ////////////////////////////////////////////////////////////////////
  // one-hot route of a pin
  typedef logic [3:0] pbpm_route_type;
  localparam pbpm_route_type ROUTE_GPIO = 4'h1;
  localparam pbpm_route_type ROUTE_FN1  = 4'h2;
  localparam pbpm_route_type ROUTE_FN2  = 4'h4;
  localparam pbpm_route_type ROUTE_FN3  = 4'h8;
endpackage : pbpm_pkg

// ==== src/pbpm_top.sv ====
// Purpose: pin function routing for ports B/C/D, port C registers
// Assumes: APB3 slave, no wait states, pads asynchronous to pclk
// Notes:   routes are one-hot: bit0 gpio, bit1..3 functions in order
//
// Behaviour
// (R1) B3: master-out, timer three or pwm source
// (R2) B5: timer one, fault three or clock
// (R3) external clock only when pll enables it
// (R4) shared pins come up as gpio
// (R5) B6: uart receive, i2c data or clock
// (R6) B7: uart transmit or i2c clock
// (R7) B8: i2c clock or can transmit
// (R8) B9: i2c data or can receive
// (R9) C0: converter A input or comparator A
// (R10) C4: converter B input or comparator B
// (R11) C2/C3: analog input or converter reference
// (R12) D5: crystal or clock, own select register
// (R13) port C registers 16 bits, absent read 0
`timescale 1ns/1ps
module pbpm_top #(
  parameter int PADDR_WIDTH = 12
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [PADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port c pads
  input  wire logic [15:0] portc_pad_in,
  output logic      [15:0] portc_pad_out,
  output logic      [15:0] portc_pad_oe,
  output logic      [15:0] portc_pullup_en,
  output logic      [15:0] portc_drive_high,
  // clock-capable pads and clock generation block
  input  wire logic        pad_b5_in,
  input  wire logic        pad_b6_in,
  input  wire logic        pad_d5_in,
  input  wire logic        pll_external_clock_input_enable,
  output logic             external_clock_input,
  // pin routes
  output pbpm_pkg::pbpm_route_type b3_route,
  output pbpm_pkg::pbpm_route_type b5_route,
  output pbpm_pkg::pbpm_route_type b6_route,
  output pbpm_pkg::pbpm_route_type b7_route,
  output pbpm_pkg::pbpm_route_type b8_route,
  output pbpm_pkg::pbpm_route_type b9_route,
  output pbpm_pkg::pbpm_route_type c0_route,
  output pbpm_pkg::pbpm_route_type c2_route,
  output pbpm_pkg::pbpm_route_type c3_route,
  output pbpm_pkg::pbpm_route_type c4_route,
  output pbpm_pkg::pbpm_route_type d5_route
);
  // elaboration check: decode needs address bits up to six
  if (PADDR_WIDTH < 7) begin : g_paddr_chk
    $error("paddr too narrow");
  end
  ////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] pullup_reg, data_reg, dir_reg, persel_reg;
  logic [15:0] asrt_reg, ien_reg, pol_reg, edge_reg;
  logic [15:0] pp_reg, drive_reg, pin_sel_reg, cd_sel_reg;
  logic [15:0] pad_s1_reg, pad_s2_reg, pad_prev_reg;
  logic [2:0]  ck_s1_reg, ck_s2_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg, ext_clk_reg;
  pbpm_pkg::pbpm_route_type route_reg [11];
  logic [15:0] rd_val, edge_set, pend_val;
  logic [3:0]  idx;
  logic        hit, setup, wr_en, ck_pick;

  // code to one-hot, unused code 3 of a two-way pin stays gpio
  function automatic pbpm_pkg::pbpm_route_type dec(
    input logic [1:0] code,
    input logic       three);
    pbpm_pkg::pbpm_route_type r;
    r = pbpm_pkg::ROUTE_GPIO;
    case (code)
      pbpm_pkg::SEL_FN1: r = pbpm_pkg::ROUTE_FN1;
      pbpm_pkg::SEL_FN2: r = pbpm_pkg::ROUTE_FN2;
      pbpm_pkg::SEL_FN3: r = three ? pbpm_pkg::ROUTE_FN3
                                   : pbpm_pkg::ROUTE_GPIO;
      default:           r = pbpm_pkg::ROUTE_GPIO;
    endcase
    return r;
  endfunction : dec

  // port c pin: gpio unless peripheral on, then pick of two
  function automatic pbpm_pkg::pbpm_route_type cdec(
    input logic per,
    input logic sel);
    pbpm_pkg::pbpm_route_type r;
    r = pbpm_pkg::ROUTE_GPIO;
    if (per) begin
      r = sel ? pbpm_pkg::ROUTE_FN2 : pbpm_pkg::ROUTE_FN1;
    end
    return r;
  endfunction : cdec
  ////////////////////////////////////////////////////////////////////
  // apb decode
  assign idx   = paddr[5:2];
  assign hit   = (paddr[PADDR_WIDTH-1:6] == '0)
               && (paddr[1:0] == 2'h0)
               && (idx <= pbpm_pkg::IDX_CD_FUNC);
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready_reg & hit;

  // no wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~hit;
      if (setup) begin
        prdata_reg <= (hit && !pwrite) ? {16'h0000, rd_val}
                                       : 32'h0000_0000;
      end
    end
  end

  // read mux, absent pins masked to zero
  always_comb begin
    case (idx)
      pbpm_pkg::IDX_PULLUP:   rd_val = pullup_reg; // R13
      pbpm_pkg::IDX_DATA:     rd_val = data_reg;
      pbpm_pkg::IDX_DIR:      rd_val = dir_reg;
      pbpm_pkg::IDX_PERSEL:   rd_val = persel_reg;
      pbpm_pkg::IDX_IRQ_ASRT: rd_val = asrt_reg;
      pbpm_pkg::IDX_IRQ_EN:   rd_val = ien_reg;
      pbpm_pkg::IDX_IRQ_POL:  rd_val = pol_reg;
      pbpm_pkg::IDX_IRQ_PEND: rd_val = pend_val;
      pbpm_pkg::IDX_EDGE:     rd_val = edge_reg;
      pbpm_pkg::IDX_PUSHPULL: rd_val = pp_reg;
      pbpm_pkg::IDX_RAW:      rd_val = pad_s2_reg
                                     & pbpm_pkg::PC_PIN_MASK;
      pbpm_pkg::IDX_DRIVE:    rd_val = drive_reg;
      pbpm_pkg::IDX_PIN_FUNC: rd_val = pin_sel_reg;
      pbpm_pkg::IDX_CD_FUNC:  rd_val = cd_sel_reg;
      default:                rd_val = 16'h0000;
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // port c control registers, absent bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_reg <= pbpm_pkg::RST_PULLUP & pbpm_pkg::PC_PIN_MASK;
      data_reg   <= pbpm_pkg::RST_ZERO;
      dir_reg    <= pbpm_pkg::RST_ZERO;
      persel_reg <= pbpm_pkg::RST_ZERO; // R4
      asrt_reg   <= pbpm_pkg::RST_ZERO;
      ien_reg    <= pbpm_pkg::RST_ZERO;
      pol_reg    <= pbpm_pkg::RST_ZERO;
      pp_reg     <= pbpm_pkg::RST_PUSHPULL & pbpm_pkg::PC_PIN_MASK;
      drive_reg  <= pbpm_pkg::RST_ZERO;
    end else if (wr_en) begin
      case (idx)
        pbpm_pkg::IDX_PULLUP:
          pullup_reg <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK; // R13
        pbpm_pkg::IDX_DATA:
          data_reg   <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK;
        pbpm_pkg::IDX_DIR:
          dir_reg    <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK;
        pbpm_pkg::IDX_PERSEL:
          persel_reg <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK;
        pbpm_pkg::IDX_IRQ_ASRT:
          asrt_reg   <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK;
        pbpm_pkg::IDX_IRQ_EN:
          ien_reg    <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK;
        pbpm_pkg::IDX_IRQ_POL:
          pol_reg    <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK;
        pbpm_pkg::IDX_PUSHPULL:
          pp_reg     <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK;
        pbpm_pkg::IDX_DRIVE:
          drive_reg  <= pwdata[15:0] & pbpm_pkg::PC_PIN_MASK;
        default: ;
      endcase
    end
  end

  // pin function selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sel_reg <= pbpm_pkg::RST_ZERO; // R4
      cd_sel_reg  <= pbpm_pkg::RST_ZERO; // R4
    end else if (wr_en && idx == pbpm_pkg::IDX_PIN_FUNC) begin
      pin_sel_reg <= pwdata[15:0];
    end else if (wr_en && idx == pbpm_pkg::IDX_CD_FUNC) begin
      cd_sel_reg  <= {14'h0000, pwdata[1:0]};
    end
  end
  ////////////////////////////////////////////////////////////////////
  // pad synchronisers, edge history taken from the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_s1_reg   <= 16'h0000;
      pad_s2_reg   <= 16'h0000;
      pad_prev_reg <= 16'h0000;
      ck_s1_reg    <= 3'h0;
      ck_s2_reg    <= 3'h0;
    end else begin
      pad_s1_reg   <= portc_pad_in;
      pad_s2_reg   <= pad_s1_reg;
      pad_prev_reg <= pad_s2_reg;
      ck_s1_reg    <= {pad_d5_in, pad_b6_in, pad_b5_in};
      ck_s2_reg    <= ck_s1_reg;
    end
  end

  // edge capture: polarity 0 rising, 1 falling; set beats clear
  assign edge_set = ien_reg & pbpm_pkg::PC_PIN_MASK
                  & ((~pol_reg & pad_s2_reg & ~pad_prev_reg)
                  |  (pol_reg & ~pad_s2_reg & pad_prev_reg));
  assign pend_val = (asrt_reg | edge_reg) & ien_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_reg <= pbpm_pkg::RST_ZERO;
    end else if (wr_en && idx == pbpm_pkg::IDX_EDGE) begin
      edge_reg <= (edge_reg & ~pwdata[15:0]) | edge_set;
    end else begin
      edge_reg <= edge_reg | edge_set;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // port c pad drive; open drain drives low only, peripheral floats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portc_pad_out    <= 16'h0000;
      portc_pad_oe     <= 16'h0000;
      portc_pullup_en  <= 16'h0000;
      portc_drive_high <= 16'h0000;
    end else begin
      portc_pad_out    <= data_reg & pp_reg;
      portc_pad_oe     <= dir_reg & ~persel_reg // R4
                        & (pp_reg | ~data_reg);
      portc_pullup_en  <= pullup_reg & ~dir_reg;
      portc_drive_high <= drive_reg;
    end
  end

  // pin routing decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 11; i++) begin
        route_reg[i] <= pbpm_pkg::ROUTE_GPIO; // R4
      end
    end else begin
      route_reg[0]  <= dec(pin_sel_reg[pbpm_pkg::F_B3 +: 2],
                           1'b1); // R1
      route_reg[1]  <= dec(pin_sel_reg[pbpm_pkg::F_B5 +: 2],
                           1'b1); // R2
      route_reg[2]  <= dec(pin_sel_reg[pbpm_pkg::F_B6 +: 2],
                           1'b1); // R5
      route_reg[3]  <= dec(pin_sel_reg[pbpm_pkg::F_B7 +: 2],
                           1'b0); // R6
      route_reg[4]  <= dec(pin_sel_reg[pbpm_pkg::F_B8 +: 2],
                           1'b0); // R7
      route_reg[5]  <= dec(pin_sel_reg[pbpm_pkg::F_B9 +: 2],
                           1'b0); // R8
      route_reg[6]  <= cdec(persel_reg[0],
                            pin_sel_reg[pbpm_pkg::F_C0]); // R9
      route_reg[7]  <= cdec(persel_reg[2],
                            pin_sel_reg[pbpm_pkg::F_C2]); // R11
      route_reg[8]  <= cdec(persel_reg[3],
                            pin_sel_reg[pbpm_pkg::F_C3]); // R11
      route_reg[9]  <= cdec(persel_reg[4],
                            pin_sel_reg[pbpm_pkg::F_C4]); // R10
      route_reg[10] <= dec(cd_sel_reg[pbpm_pkg::F_D5 +: 2],
                           1'b0); // R12
    end
  end

  // external clock: pick the routed pin, pass only when enabled
  always_comb begin
    ck_pick = 1'b0;
    if (route_reg[1] == pbpm_pkg::ROUTE_FN3) begin
      ck_pick = ck_s2_reg[0];
    end else if (route_reg[2] == pbpm_pkg::ROUTE_FN3) begin
      ck_pick = ck_s2_reg[1];
    end else if (route_reg[10] == pbpm_pkg::ROUTE_FN2) begin
      ck_pick = ck_s2_reg[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clk_reg <= 1'b0;
    end else begin
      ext_clk_reg <= pll_external_clock_input_enable & ck_pick; // R3
    end
  end
  ////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign external_clock_input = ext_clk_reg;
  assign b3_route = route_reg[0];
  assign b5_route = route_reg[1];
  assign b6_route = route_reg[2];
  assign b7_route = route_reg[3];
  assign b8_route = route_reg[4];
  assign b9_route = route_reg[5];
  assign c0_route = route_reg[6];
  assign c2_route = route_reg[7];
  assign c3_route = route_reg[8];
  assign c4_route = route_reg[9];
  assign d5_route = route_reg[10];
  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence sel_write(logic [3:0] i, logic [1:0] c);
    psel && penable && pwrite && pready && hit
    && paddr[5:2] == i && pwdata[1:0] == c;
  endsequence

  b3_route_a: assert property ( // R1
    sel_write(pbpm_pkg::IDX_PIN_FUNC, pbpm_pkg::SEL_FN3)
    |=> ##1 b3_route == pbpm_pkg::ROUTE_FN3)
    else $error("b3 not on pwm source");
  b5_route_a: assert property ( // R2
    pin_sel_reg[pbpm_pkg::F_B5 +: 2] == pbpm_pkg::SEL_FN2
    |=> b5_route == pbpm_pkg::ROUTE_FN2)
    else $error("b5 not on fault input");
  external_clock_input_gate_a: assert property ( // R3
    !pll_external_clock_input_enable |=> !external_clock_input)
    else $error("clock passed while disabled");
  external_clock_input_pass_a: assert property ( // R3
    pll_external_clock_input_enable && b5_route == pbpm_pkg::ROUTE_FN3
    |=> external_clock_input == $past(ck_s2_reg[0]))
    else $error("enabled clock not routed");
  reset_gpio_a: assert property ($rose(presetn) // R4
    |-> b3_route == pbpm_pkg::ROUTE_GPIO
     && c0_route == pbpm_pkg::ROUTE_GPIO
     && portc_pad_oe == 16'h0000)
    else $error("pin not gpio after reset");
  b6_route_a: assert property ( // R5
    pin_sel_reg[pbpm_pkg::F_B6 +: 2] == pbpm_pkg::SEL_FN1
    |=> b6_route == pbpm_pkg::ROUTE_FN1)
    else $error("b6 not on uart receive");
  b7_route_a: assert property ( // R6
    pin_sel_reg[pbpm_pkg::F_B7 +: 2] == pbpm_pkg::SEL_FN3
    |=> b7_route == pbpm_pkg::ROUTE_GPIO)
    else $error("b7 bad code not gpio");
  b8_route_a: assert property ( // R7
    pin_sel_reg[pbpm_pkg::F_B8 +: 2] == pbpm_pkg::SEL_FN2
    |=> b8_route == pbpm_pkg::ROUTE_FN2)
    else $error("b8 not on can transmit");
  b9_route_a: assert property ( // R8
    pin_sel_reg[pbpm_pkg::F_B9 +: 2] == pbpm_pkg::SEL_FN1
    |=> b9_route == pbpm_pkg::ROUTE_FN1)
    else $error("b9 not on i2c data");
  c0_route_a: assert property ( // R9
    persel_reg[0] && pin_sel_reg[pbpm_pkg::F_C0]
    |=> c0_route == pbpm_pkg::ROUTE_FN2 && portc_pad_oe[0] == 1'b0)
    else $error("c0 not on comparator");
  c4_route_a: assert property ( // R10
    !persel_reg[4] |=> c4_route == pbpm_pkg::ROUTE_GPIO)
    else $error("c4 left gpio");
  c2_ref_a: assert property ( // R11
    persel_reg[2] && pin_sel_reg[pbpm_pkg::F_C2]
    |=> c2_route == pbpm_pkg::ROUTE_FN2)
    else $error("c2 not on reference");
  d5_route_a: assert property ( // R12
    cd_sel_reg[pbpm_pkg::F_D5 +: 2] == pbpm_pkg::SEL_FN1
    |=> d5_route == pbpm_pkg::ROUTE_FN1)
    else $error("d5 not on crystal");
  read_mask_a: assert property (pready && !pslverr // R13
    |-> prdata[31:16] == 16'h0000
     && (($past(paddr[5:2]) > pbpm_pkg::IDX_DRIVE)
     || (prdata[15:0] & ~pbpm_pkg::PC_PIN_MASK) == 16'h0000))
    else $error("absent bit read nonzero");
endmodule : pbpm_top

// ==== verif/tb_port_bcd_pin_mux_portc_regs.sv ====
// Purpose: self-checking bench for the pin mux and port C registers
// Assumes: zero wait state apb slave, routes settle within three edges
// Notes:   model keeps register images, compared at every read
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value %s exp %h got %h", what, exp, got); \
    end \
  end
module tb_port_bcd_pin_mux_portc_regs;
  // clock, reset and apb
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // pads and clock block
  logic [15:0] portc_pad_in;
  logic [15:0] portc_pad_out;
  logic [15:0] portc_pad_oe;
  logic [15:0] portc_pullup_en;
  logic [15:0] portc_drive_high;
  logic        pad_b5_in;
  logic        pad_b6_in;
  logic        pad_d5_in;
  logic        pll_external_clock_input_enable;
  logic        external_clock_input;
  pbpm_pkg::pbpm_route_type rts [0:10];
  // bench state
  integer      error_cnt = 0;
  integer      check_count = 0;
  integer      seed = 32'h4697;
  logic [15:0] mdl [0:15];

  pbpm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portc_pad_in(portc_pad_in), .portc_pad_out(portc_pad_out),
    .portc_pad_oe(portc_pad_oe), .portc_pullup_en(portc_pullup_en),
    .portc_drive_high(portc_drive_high), .pad_b5_in(pad_b5_in),
    .pad_b6_in(pad_b6_in), .pad_d5_in(pad_d5_in),
    .pll_external_clock_input_enable(pll_external_clock_input_enable),
    .external_clock_input(external_clock_input),
    .b3_route(rts[0]), .b5_route(rts[1]), .b6_route(rts[2]),
    .b7_route(rts[3]), .b8_route(rts[4]), .b9_route(rts[5]),
    .c0_route(rts[6]), .c2_route(rts[7]), .c3_route(rts[8]),
    .c4_route(rts[9]), .d5_route(rts[10]));

  ////////////////////////////////////////////////////////////////////
  // clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // stored bits per register, zero where writes are dropped
  function automatic logic [15:0] keep_mask(input int idx);
    case (idx)
      7, 8, 10: return 16'h0000;
      12:       return 16'hffff;
      13:       return 16'h0003;
      default:  return pbpm_pkg::PC_PIN_MASK;
    endcase
  endfunction : keep_mask

  // model reset image
  task init_mdl;
    for (int i = 0; i < 16; i++) mdl[i] = 16'h0000;
    mdl[0] = 16'h11ff;
    mdl[9] = 16'h11ff;
  endtask : init_mdl

  // one apb transfer, held until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // register write through the model
  task automatic wr_reg(input int idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 12'(idx * 4), wd, rd, err);
    `CHK("write error", 1'b0, err)
    if (keep_mask(idx) != 16'h0000) mdl[idx] = wd[15:0] & keep_mask(idx);
  endtask : wr_reg

  // register read compared with the model
  task automatic rd_chk(input int idx);
    logic [31:0] rd;
    logic        err;
    logic [15:0] ex;
    ex = (idx == 7) ? ((mdl[4] | mdl[8]) & mdl[5]) : mdl[idx];
    apb(1'b0, 12'(idx * 4), 32'h0, rd, err);
    `CHK("read data", {16'h0000, ex}, rd)
    `CHK("read error", 1'b0, err)
  endtask : rd_chk

  // expected b pin route for a two-bit code
  function automatic logic [3:0] b_exp(input int i, input int c);
    if (c == 3 && i >= 3) return pbpm_pkg::ROUTE_GPIO;
    return pbpm_pkg::ROUTE_GPIO << c;
  endfunction : b_exp

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end

  // main sequence
  initial begin
    logic [31:0] rd;
    logic        err;
    logic [15:0] tmp;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; portc_pad_in = 16'h0000;
    pad_b5_in = 1'b0; pad_b6_in = 1'b0; pad_d5_in = 1'b0;
    pll_external_clock_input_enable = 1'b0;
    init_mdl();
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 11; i++) `CHK("route", pbpm_pkg::ROUTE_GPIO, rts[i])
    for (int i = 0; i < 14; i++) rd_chk(i);
    $display("test reset done");
    // random writes, read-only places included
    for (int i = 0; i < 14; i++) wr_reg(i, $random(seed));
    for (int i = 0; i < 14; i++) rd_chk(i);
    apb(1'b0, 12'h038, 32'h0, rd, err);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, 12'h005, 32'hffff, rd, err);
    `CHK("misaligned error", 1'b1, err)
    rd_chk(1);
    repeat (3) @(posedge pclk);
    tmp = mdl[2] & ~mdl[3] & (mdl[9] | ~mdl[1]);
    `CHK("pad oe", tmp, portc_pad_oe)
    `CHK("pad out", mdl[1] & mdl[9], portc_pad_out)
    `CHK("pullup", mdl[0] & ~mdl[2], portc_pullup_en)
    `CHK("drive", mdl[11], portc_drive_high)
    tmp = 16'($random(seed));
    portc_pad_in <= tmp;
    mdl[10] = tmp & pbpm_pkg::PC_PIN_MASK;
    // pads rose from zero: enabled rising-polarity bits latch
    mdl[8] = mdl[10] & mdl[5] & ~mdl[6];
    repeat (4) @(posedge pclk);
    for (int i = 7; i < 11; i++) rd_chk(i);
    // writing ones clears every latched edge
    wr_reg(8, 32'h0000_ffff);
    mdl[8] = 16'h0000;
    rd_chk(8);
    $display("test registers done");
    // port b routes, one pin at a time
    wr_reg(13, 0);
    for (int i = 0; i < 6; i++) begin
      for (int c = 0; c < 4; c++) begin
        wr_reg(12, 32'(c) << (2 * i));
        repeat (3) @(posedge pclk);
        for (int j = 0; j < 6; j++) begin
          `CHK("b route", (j == i) ? b_exp(i, c) : 4'h1, rts[j])
        end
      end
    end
    // port c routes by peripheral select and function bit
    for (int p = 0; p < 2; p++) begin
      wr_reg(3, p ? 32'h001d : 32'h0);
      for (int s = 0; s < 2; s++) begin
        wr_reg(12, s ? 32'hf000 : 32'h0);
        repeat (3) @(posedge pclk);
        for (int j = 6; j < 10; j++) begin
          `CHK("c route", p ? (s ? 4'h4 : 4'h2) : 4'h1, rts[j])
        end
      end
    end
    // port d pin 5 from its own select
    wr_reg(12, 0);
    for (int c = 0; c < 4; c++) begin
      wr_reg(13, c);
      repeat (3) @(posedge pclk);
      `CHK("d5 route", (c == 1) ? 4'h2 : (c == 2) ? 4'h4 : 4'h1, rts[10])
    end
    $display("test routes done");
    // external clock from each source, gated by the pll enable
    for (int k = 0; k < 3; k++) begin
      wr_reg(12, (k == 0) ? 32'h000c : (k == 1) ? 32'h0030 : 32'h0);
      wr_reg(13, (k == 2) ? 32'h2 : 32'h0);
      pad_b5_in <= (k == 0);
      pad_b6_in <= (k == 1);
      pad_d5_in <= (k == 2);
      pll_external_clock_input_enable <= 1'b0;
      repeat (6) @(posedge pclk);
      `CHK("clock gated", 1'b0, external_clock_input)
      pll_external_clock_input_enable <= 1'b1;
      repeat (6) @(posedge pclk);
      `CHK("clock high", 1'b1, external_clock_input)
      pad_b5_in <= 1'b0;
      pad_b6_in <= 1'b0;
      pad_d5_in <= 1'b0;
      repeat (6) @(posedge pclk);
      `CHK("clock low", 1'b0, external_clock_input)
    end
    $display("test clock done");
    // reset in mid-run returns every pin to gpio
    wr_reg(12, 32'h0015);
    wr_reg(13, 32'h1);
    presetn <= 1'b0;
    init_mdl();
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 11; i++) `CHK("route", pbpm_pkg::ROUTE_GPIO, rts[i])
    presetn <= 1'b1;
    // after release the selects read back at their reset value
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      `CHK("route", pbpm_pkg::ROUTE_GPIO, rts[i])
    end
    rd_chk(12);
    rd_chk(13);
    $display("test second reset done");
    stop_test();
  end
endmodule : tb_port_bcd_pin_mux_portc_regs
